// ==== src/core_special_register_bank.sv ====
`timescale 1ns/1ns
// How it works
// - unmapped data memory addresses read back zero, writes there vanish
// - indirect port has no storage, it works on the address in the pointer
// - control registers are static flops that hold without refresh
// - second port direction register loads all ones on every reset
// - pc high latch feeds pc bits 12 to 8 when the counter is written
// - master and watchdog resets use other values, power and brown-out the first, save the power cause bit that brown-out keeps
// - mirrored bank 1 locations reach the bank 0 register
module core_special_register_bank (
  // clock, enable and power-on reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // reset causes, one-cycle pulses
  input wire logic brown_out_reset,
  input wire logic external_master_reset,
  input wire logic watchdog_reset,
  // register port
  input wire sfr_pkg::bus_req_t req,
  output logic [7:0] rdata,
  // datapath
  input wire logic pc_step,
  input wire logic flag_we,
  input wire logic [2:0] flag_in,
  // pins
  input wire logic [4:0] first_port_pins,
  input wire logic [7:0] second_port_pins,
  output sfr_pkg::port_out_t ports,
  // peripheral controls
  output logic [7:0] option_bits,
  output logic [7:0] adc_main,
  output logic [1:0] adc_pins,
  output logic [7:0] intr_flags,
  output logic [12:0] pc
);

  // ***************************************
  // decode
  // ***************************************
  logic other_rst;
  logic any_rst;
  logic indirect;
  logic [7:0] eff;
  sfr_pkg::reg_sel_t sel;
  logic wr_go;
  logic [7:0] wd;
  logic [7:0] rd_val;
  logic [6:0] gp_index;
  logic [7:0] timer;
  logic [7:0] file_select_pointer;
  logic [7:0] status;
  logic [7:0] conversion_result_value;
  logic [4:0] pc_high_latch;
  logic [1:0] power_reset_cause;

  function automatic sfr_pkg::reg_sel_t decode(input logic [7:0] a);
    logic [7:0] b0;
    b0 = a & ~sfr_pkg::BANK1_BIT;
    decode = sfr_pkg::SEL_NONE;
    if (a[6:0] >= sfr_pkg::GP_FIRST && a[6:0] <= sfr_pkg::GP_LAST) begin
      decode = sfr_pkg::SEL_GPR;
    end else begin
      // unmirrored registers of both banks first
      case (a)
        sfr_pkg::OFS_OPTION: decode = sfr_pkg::SEL_OPTION;
        sfr_pkg::OFS_DIR1: decode = sfr_pkg::SEL_DIR1;
        sfr_pkg::OFS_DIR2: decode = sfr_pkg::SEL_DIR2;
        sfr_pkg::OFS_CAUSE: decode = sfr_pkg::SEL_CAUSE;
        sfr_pkg::OFS_CONV_PINS: decode = sfr_pkg::SEL_CONV_PINS;
        sfr_pkg::OFS_TIMER: decode = sfr_pkg::SEL_TIMER;
        sfr_pkg::OFS_PORT1: decode = sfr_pkg::SEL_PORT1;
        sfr_pkg::OFS_PORT2: decode = sfr_pkg::SEL_PORT2;
        sfr_pkg::OFS_CONV_MAIN: decode = sfr_pkg::SEL_CONV_MAIN;
        default: begin
          case (b0)
            sfr_pkg::OFS_PC_LOW: decode = sfr_pkg::SEL_PC_LOW;
            sfr_pkg::OFS_STATUS: decode = sfr_pkg::SEL_STATUS;
            sfr_pkg::OFS_POINTER: decode = sfr_pkg::SEL_POINTER;
            sfr_pkg::OFS_CONV_RESULT: decode = sfr_pkg::SEL_CONV_RESULT;
            sfr_pkg::OFS_PC_HIGH: decode = sfr_pkg::SEL_PC_HIGH;
            sfr_pkg::OFS_INTR: decode = sfr_pkg::SEL_INTR;
            default: decode = sfr_pkg::SEL_NONE;
          endcase
        end
      endcase
    end
  endfunction

  // reset causes beat any software write in the same cycle
  assign other_rst = external_master_reset | watchdog_reset;
  assign any_rst = other_rst | brown_out_reset;
  assign wr_go = ce && req.wr && !any_rst;
  assign wd = req.wdata;

  // effective address, then register select
  always_comb begin
    indirect = (req.addr == sfr_pkg::OFS_INDIRECT[6:0]);
    // upper bank bits are ignored, software keeps them clear
    eff = indirect ? file_select_pointer : {status[sfr_pkg::ST_BANK], req.addr};
    sel = decode(eff);
    gp_index = eff[6:0] - sfr_pkg::GP_FIRST;
  end

  // ***************************************
  // pointer, timer and result storage
  // ***************************************
  // static cells
  // power-on and brown-out clear the unknown values to zero, master and watchdog resets keep them
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      timer <= sfr_pkg::RST_ZERO;
      file_select_pointer <= sfr_pkg::RST_ZERO;
      conversion_result_value <= sfr_pkg::RST_ZERO;
    end else if (ce) begin
      if (brown_out_reset) begin
        timer <= sfr_pkg::RST_ZERO;
        file_select_pointer <= sfr_pkg::RST_ZERO;
        conversion_result_value <= sfr_pkg::RST_ZERO;
      end else if (wr_go) begin
        if (sel == sfr_pkg::SEL_TIMER) timer <= wd;
        if (sel == sfr_pkg::SEL_POINTER) file_select_pointer <= wd;
        if (sel == sfr_pkg::SEL_CONV_RESULT) conversion_result_value <= wd;
      end
    end
  end

  // ***************************************
  // status
  // ***************************************
  // timeout and power-down flags are read-only to software;
  // datapath flags win over a software write in the same cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status <= sfr_pkg::RST_STATUS;
    end else if (ce) begin
      if (brown_out_reset) begin
        status <= sfr_pkg::RST_STATUS;
      end else if (other_rst) begin
        status[7:5] <= 3'h0;
        status[sfr_pkg::ST_TO] <= ~watchdog_reset;
      end else begin
        if (wr_go && sel == sfr_pkg::SEL_STATUS) begin
          status[7:5] <= wd[7:5];
          status[2:0] <= wd[2:0];
        end
        if (flag_we) begin
          status[2:0] <= flag_in;
        end
      end
    end
  end

  // ***************************************
  // program counter
  // ***************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pc_high_latch <= sfr_pkg::RST_ZERO[4:0];
    end else if (ce) begin
      if (any_rst) begin
        pc_high_latch <= sfr_pkg::RST_ZERO[4:0];
      end else if (wr_go && sel == sfr_pkg::SEL_PC_HIGH) begin
        pc_high_latch <= wd[4:0];
      end
    end
  end

  // latch to pc high
  // the high byte is only reachable through the latch
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pc <= sfr_pkg::RST_PC;
    end else if (ce) begin
      if (any_rst) begin
        pc <= sfr_pkg::RST_PC;
      end else if (wr_go && sel == sfr_pkg::SEL_PC_LOW) begin
        pc <= {pc_high_latch, wd};
      end else if (pc_step) begin
        pc <= pc + 13'h0001;
      end
    end
  end

  // ***************************************
  // ports
  // ***************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ports.a_latch <= sfr_pkg::RST_ZERO[4:0];
      ports.b_latch <= sfr_pkg::RST_ZERO;
      ports.a_dir <= sfr_pkg::RST_DIR1;
      ports.b_dir <= sfr_pkg::RST_DIR2;
    end else if (ce) begin
      if (any_rst) begin
        ports.b_dir <= sfr_pkg::RST_DIR2;
        ports.a_dir <= sfr_pkg::RST_DIR1;
        ports.a_latch[3:0] <= 4'h0;
        if (brown_out_reset) begin
          ports.a_latch[4] <= 1'b0;
          ports.b_latch <= sfr_pkg::RST_ZERO;
        end
      end else if (wr_go) begin
        if (sel == sfr_pkg::SEL_PORT1) ports.a_latch <= wd[4:0];
        if (sel == sfr_pkg::SEL_PORT2) ports.b_latch <= wd;
        if (sel == sfr_pkg::SEL_DIR1) ports.a_dir <= wd[4:0];
        if (sel == sfr_pkg::SEL_DIR2) ports.b_dir <= wd;
      end
    end
  end

  // ***************************************
  // peripheral control registers
  // ***************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      option_bits <= sfr_pkg::RST_OPTION;
      adc_main <= sfr_pkg::RST_ZERO;
      adc_pins <= sfr_pkg::RST_ZERO[1:0];
      intr_flags <= sfr_pkg::RST_ZERO;
    end else if (ce) begin
      if (any_rst) begin
        option_bits <= sfr_pkg::RST_OPTION;
        adc_main <= sfr_pkg::RST_ZERO;
        adc_pins <= sfr_pkg::RST_ZERO[1:0];
        // flag in bit 0 survives other resets
        intr_flags[7:1] <= 7'h00;
        if (brown_out_reset) intr_flags[0] <= 1'b0;
      end else if (wr_go) begin
        if (sel == sfr_pkg::SEL_OPTION) option_bits <= wd;
        if (sel == sfr_pkg::SEL_CONV_MAIN) adc_main <= wd;
        if (sel == sfr_pkg::SEL_CONV_PINS) adc_pins <= wd[1:0];
        if (sel == sfr_pkg::SEL_INTR) intr_flags <= wd;
      end
    end
  end

  // power-on clears both cause bits; brown-out clears its own only
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      power_reset_cause <= sfr_pkg::RST_CAUSE;
    end else if (ce) begin
      if (brown_out_reset) begin
        power_reset_cause[sfr_pkg::CAUSE_BROWN] <= 1'b0;
      end else if (wr_go && sel == sfr_pkg::SEL_CAUSE) begin
        power_reset_cause <= wd[1:0];
      end
    end
  end

  // ***************************************
  // read path
  // ***************************************
  // zero when unmapped
  always_comb begin
    case (sel)
      sfr_pkg::SEL_TIMER: rd_val = timer;
      sfr_pkg::SEL_PC_LOW: rd_val = pc[7:0];
      sfr_pkg::SEL_STATUS: rd_val = status;
      sfr_pkg::SEL_POINTER: rd_val = file_select_pointer;
      sfr_pkg::SEL_PORT1: rd_val = {3'h0, first_port_pins};
      sfr_pkg::SEL_PORT2: rd_val = second_port_pins;
      sfr_pkg::SEL_CONV_MAIN: rd_val = adc_main;
      sfr_pkg::SEL_CONV_RESULT: rd_val = conversion_result_value;
      sfr_pkg::SEL_PC_HIGH: rd_val = {3'h0, pc_high_latch};
      sfr_pkg::SEL_INTR: rd_val = intr_flags;
      sfr_pkg::SEL_OPTION: rd_val = option_bits;
      sfr_pkg::SEL_DIR1: rd_val = {3'h0, ports.a_dir};
      sfr_pkg::SEL_DIR2: rd_val = ports.b_dir;
      sfr_pkg::SEL_CAUSE: rd_val = {6'h00, power_reset_cause};
      sfr_pkg::SEL_CONV_PINS: rd_val = {6'h00, adc_pins};
      default: rd_val = sfr_pkg::RST_ZERO;
    endcase
  end

  // ram and read register share one flop stage
  gp_ram u_ram (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ce(ce),
    .wr_en(wr_go && sel == sfr_pkg::SEL_GPR),
    .rd_en(ce && req.rd),
    .use_mem(sel == sfr_pkg::SEL_GPR),
    .addr(gp_index),
    .wdata(wd),
    .alt_data(rd_val),
    .rdata(rdata)
  );

  // ***************************************
  // checks
  // ***************************************
  a_unmapped_reads_zero: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && req.rd && sel == sfr_pkg::SEL_NONE |=> ce |-> rdata == 8'h00)
    else $error("unmapped read not zero");

  a_indirect_uses_ptr: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && req.rd && indirect && file_select_pointer == 8'h86
      |=> ce |-> rdata == $past(ports.b_dir))
    else $error("indirect read missed pointer target");

  a_static_hold: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !ce || (!req.wr && !any_rst) |=> $stable(option_bits) && $stable(file_select_pointer))
    else $error("register changed without write");

  a_dir_all_ones: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && any_rst |=> ports.b_dir == 8'hff)
    else $error("direction not all ones after reset");

  a_bank_select: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    wr_go && req.addr == 7'h06 && status[sfr_pkg::ST_BANK]
      |=> ports.b_dir == $past(req.wdata) && $stable(ports.b_latch))
    else $error("bank 1 write missed");

  a_latch_to_pc: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    wr_go && sel == sfr_pkg::SEL_PC_LOW |=> pc[12:8] == $past(pc_high_latch))
    else $error("pc high not from latch");

  a_other_rst_keeps: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && other_rst && !brown_out_reset
      |=> timer == $past(timer) && power_reset_cause == $past(power_reset_cause)
        && option_bits == 8'hff)
    else $error("other reset values wrong");

  a_brown_out_clears: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && brown_out_reset |=> !power_reset_cause[sfr_pkg::CAUSE_BROWN] && status == 8'h18)
    else $error("brown-out values wrong");

  a_mirror_shared: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    wr_go && !indirect && status[sfr_pkg::ST_BANK] && req.addr == 7'h04
      |=> file_select_pointer == $past(req.wdata))
    else $error("mirrored write missed bank 0 register");

endmodule

// ==== src/sfr_pkg.sv ====
package sfr_pkg;

  // ***************************************
  // widths
  // ***************************************
  localparam int unsigned FIRST_PORT_W = 5;
  localparam int unsigned PC_HIGH_W = 5;
  localparam int unsigned PC_W = 13;
  localparam int unsigned GP_DEPTH = 68;

  // ***************************************
  // register offsets, full 8-bit file addresses
  // ***************************************
  localparam logic [7:0] OFS_INDIRECT = 8'h00;
  localparam logic [7:0] OFS_TIMER = 8'h01;
  localparam logic [7:0] OFS_PC_LOW = 8'h02;
  localparam logic [7:0] OFS_STATUS = 8'h03;
  localparam logic [7:0] OFS_POINTER = 8'h04;
  localparam logic [7:0] OFS_PORT1 = 8'h05;
  localparam logic [7:0] OFS_PORT2 = 8'h06;
  localparam logic [7:0] OFS_CONV_MAIN = 8'h08;
  localparam logic [7:0] OFS_CONV_RESULT = 8'h09;
  localparam logic [7:0] OFS_PC_HIGH = 8'h0a;
  localparam logic [7:0] OFS_INTR = 8'h0b;
  localparam logic [7:0] OFS_OPTION = 8'h81;
  localparam logic [7:0] OFS_DIR1 = 8'h85;
  localparam logic [7:0] OFS_DIR2 = 8'h86;
  localparam logic [7:0] OFS_CAUSE = 8'h87;
  localparam logic [7:0] OFS_CONV_PINS = 8'h88;
  localparam logic [7:0] BANK1_BIT = 8'h80;
  // general purpose ram window, mirrored into bank 1
  localparam logic [6:0] GP_FIRST = 7'h0c;
  localparam logic [6:0] GP_LAST = 7'h4f;

  // ***************************************
  // field positions
  // ***************************************
  localparam int unsigned ST_BANK = 5;
  localparam int unsigned ST_TO = 4;
  localparam int unsigned ST_PD = 3;
  localparam int unsigned CAUSE_POWER = 1;
  localparam int unsigned CAUSE_BROWN = 0;

  // ***************************************
  // values after reset
  // ***************************************
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [4:0] RST_DIR1 = 5'h1f;
  localparam logic [7:0] RST_DIR2 = 8'hff;
  localparam logic [1:0] RST_CAUSE = 2'h0;
  localparam logic [12:0] RST_PC = 13'h0000;

  // ***************************************
  // types
  // ***************************************
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic [4:0] a_latch;
    logic [4:0] a_dir;
    logic [7:0] b_latch;
    logic [7:0] b_dir;
  } port_out_t;

  typedef enum logic [4:0] {
    SEL_NONE, SEL_GPR, SEL_TIMER, SEL_PC_LOW, SEL_STATUS, SEL_POINTER, SEL_PORT1,
    SEL_PORT2, SEL_CONV_MAIN, SEL_CONV_RESULT, SEL_PC_HIGH, SEL_INTR, SEL_OPTION,
    SEL_DIR1, SEL_DIR2, SEL_CAUSE, SEL_CONV_PINS
  } reg_sel_t;

endpackage

// ==== src/gp_ram.sv ====
`timescale 1ns/1ns
// ***************************************
// general purpose ram with registered read port
// ***************************************
module gp_ram (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // access
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic use_mem,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] alt_data,
  output logic [7:0] rdata
);

  logic [7:0] mem [sfr_pkg::GP_DEPTH];

  // ram cells carry no reset, like the real array
  always_ff @(posedge sys_clk) begin
    if (ce && wr_en) begin
      mem[addr] <= wdata;
    end
  end

  // one read register serves ram and registers alike
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= sfr_pkg::RST_ZERO;
    end else if (ce) begin
      if (rd_en) begin
        rdata <= use_mem ? mem[addr] : alt_data;
      end else begin
        rdata <= sfr_pkg::RST_ZERO;
      end
    end
  end

endmodule

// ==== tb/cpu_model.sv ====
`timescale 1ns/1ns
// ***************************************
// datapath side that reaches data memory
// ***************************************
module cpu_model (
  // clock
  input wire logic sys_clk,
  // register port
  output sfr_pkg::bus_req_t req,
  input wire logic [7:0] rdata,
  // datapath strobes
  output logic pc_step,
  output logic flag_we,
  output logic [2:0] flag_in
);
  // everything idle from time zero
  initial begin
    req = '0;
    pc_step = 1'b0;
    flag_we = 1'b0;
    flag_in = 3'h0;
  end

  // one-cycle write strobe beside address and data
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == sfr_pkg::OFS_STATUS[6:0]) begin
      v[7:6] = 2'b00;
    end
    @(posedge sys_clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req <= '0;
    // let the edge's register updates settle before a caller looks
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req <= '0;
    #1;
    d = rdata;
  endtask

  // single increment of the program counter
  task automatic step();
    @(posedge sys_clk);
    pc_step <= 1'b1;
    @(posedge sys_clk);
    pc_step <= 1'b0;
  endtask

  // arithmetic flags as an instruction would leave them
  task automatic flags(input logic [2:0] f);
    @(posedge sys_clk);
    flag_we <= 1'b1;
    flag_in <= f;
    @(posedge sys_clk);
    flag_we <= 1'b0;
  endtask
endmodule

// ==== tb/core_special_register_bank_tb_top.sv ====
`timescale 1ns/1ns
module core_special_register_bank_tb_top;
  logic sys_clk;
  logic resetn;
  logic brown_out_reset;
  logic external_master_reset;
  logic watchdog_reset;
  logic ce;
  logic [4:0] first_port_pins;
  logic [7:0] second_port_pins;
  sfr_pkg::bus_req_t req;
  logic [7:0] rdata;
  logic pc_step;
  logic flag_we;
  logic [2:0] flag_in;
  sfr_pkg::port_out_t ports;
  logic [7:0] option_bits;
  logic [7:0] adc_main;
  logic [1:0] adc_pins;
  logic [7:0] intr_flags;
  logic [12:0] pc;
  int n_fail;
  int num_checks;

  // ***************************************
  // block and datapath model
  // ***************************************
  core_special_register_bank i_core_special_register_bank (
    .sys_clk(sys_clk), .resetn(resetn), .ce(ce),
    .brown_out_reset(brown_out_reset), .external_master_reset(external_master_reset),
    .watchdog_reset(watchdog_reset), .req(req), .rdata(rdata), .pc_step(pc_step),
    .flag_we(flag_we), .flag_in(flag_in), .first_port_pins(first_port_pins),
    .second_port_pins(second_port_pins), .ports(ports), .option_bits(option_bits),
    .adc_main(adc_main), .adc_pins(adc_pins), .intr_flags(intr_flags), .pc(pc)
  );
  cpu_model i_cpu_model (
    .sys_clk(sys_clk), .req(req), .rdata(rdata), .pc_step(pc_step),
    .flag_we(flag_we), .flag_in(flag_in)
  );

  // ***************************************
  // helpers
  // ***************************************
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input string what, input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_cpu_model.rd(a, d);
    chk(what, 16'(exp), 16'(d));
  endtask

  // writes status, so the flags are lost on purpose
  task automatic sel_bank(input logic b);
    i_cpu_model.wr(7'h03, b ? 8'h20 : 8'h00);
  endtask

  // 0 brown-out, 1 master, 2 watchdog; effect checked after the edge lands
  task automatic pulse(input int which);
    @(posedge sys_clk);
    brown_out_reset <= (which == 0);
    external_master_reset <= (which == 1);
    watchdog_reset <= (which == 2);
    @(posedge sys_clk);
    brown_out_reset <= 1'b0;
    external_master_reset <= 1'b0;
    watchdog_reset <= 1'b0;
    #1;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ***************************************
  // scenarios
  // ***************************************
  task automatic t_reset();
    chk("b_dir", 16'h00ff, 16'(ports.b_dir));
    chk("a_dir", 16'h001f, 16'(ports.a_dir));
    chk("option", 16'h00ff, 16'(option_bits));
    chk("pc", 16'h0000, 16'(pc));
    chk("adc_main", 16'h0000, 16'(adc_main));
    rchk("status", 7'h03, 8'h18);
    rchk("pc latch", 7'h0a, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_unmapped();
    i_cpu_model.wr(7'h07, 8'haa);
    rchk("hole 07", 7'h07, 8'h00);
    rchk("hole 50", 7'h50, 8'h00);
    sel_bank(1'b1);
    rchk("hole df", 7'h5f, 8'h00);
    sel_bank(1'b0);
    $display("test unmapped done");
  endtask

  task automatic t_indirect();
    i_cpu_model.wr(7'h04, 8'h20);
    i_cpu_model.wr(7'h00, 8'h5a);
    rchk("ram 20", 7'h20, 8'h5a);
    rchk("indirect 20", 7'h00, 8'h5a);
    i_cpu_model.wr(7'h04, 8'h86);
    i_cpu_model.wr(7'h00, 8'h3c);
    chk("b_dir", 16'h003c, 16'(ports.b_dir));
    rchk("indirect 86", 7'h00, 8'h3c);
    i_cpu_model.wr(7'h04, 8'h00);
    rchk("indirect self", 7'h00, 8'h00);
    $display("test indirect done");
  endtask

  task automatic t_bank();
    rchk("pins a", 7'h05, 8'h15);
    rchk("pins b", 7'h06, 8'ha3);
    sel_bank(1'b1);
    rchk("dir 2 bank 1", 7'h06, 8'h3c);
    i_cpu_model.wr(7'h01, 8'h55);
    chk("option", 16'h0055, 16'(option_bits));
    i_cpu_model.wr(7'h0a, 8'h13);
    i_cpu_model.wr(7'h04, 8'h24);
    i_cpu_model.wr(7'h20, 8'h77);
    sel_bank(1'b0);
    rchk("timer", 7'h01, 8'h00);
    rchk("pc latch mirror", 7'h0a, 8'h13);
    rchk("pointer mirror", 7'h04, 8'h24);
    rchk("ram mirror", 7'h20, 8'h77);
    $display("test bank done");
  endtask

  task automatic t_pc();
    i_cpu_model.wr(7'h02, 8'h44);
    chk("pc load", 16'h1344, 16'(pc));
    i_cpu_model.step();
    #1;
    chk("pc step", 16'h1345, 16'(pc));
    rchk("pc low", 7'h02, 8'h45);
    // long idle: nothing may decay or need a refresh
    repeat (50) @(posedge sys_clk);
    chk("option hold", 16'h0055, 16'(option_bits));
    rchk("ram hold", 7'h20, 8'h77);
    // enable low freezes everything, so this timer write must not land
    @(posedge sys_clk);
    ce <= 1'b0;
    i_cpu_model.wr(7'h01, 8'h11);
    @(posedge sys_clk);
    ce <= 1'b1;
    rchk("timer frozen", 7'h01, 8'h00);
    $display("test pc done");
  endtask

  task automatic t_resets();
    i_cpu_model.wr(7'h04, 8'h55);
    i_cpu_model.wr(7'h0b, 8'h81);
    i_cpu_model.wr(7'h05, 8'h1f);
    i_cpu_model.wr(7'h06, 8'h5a);
    i_cpu_model.wr(7'h08, 8'hc5);
    chk("latches", 16'h1f5a, {3'h0, ports.a_latch, ports.b_latch});
    chk("intr", 16'h0081, 16'(intr_flags));
    chk("adc_main", 16'h00c5, 16'(adc_main));
    sel_bank(1'b1);
    i_cpu_model.wr(7'h08, 8'h03);
    chk("adc_pins", 16'h0003, 16'(adc_pins));
    sel_bank(1'b0);
    i_cpu_model.flags(3'h5);
    pulse(1);
    chk("b_dir master", 16'h00ff, 16'(ports.b_dir));
    chk("option master", 16'h00ff, 16'(option_bits));
    chk("pc master", 16'h0000, 16'(pc));
    chk("latches master", 16'h105a, {3'h0, ports.a_latch, ports.b_latch});
    chk("intr master", 16'h0001, 16'(intr_flags));
    chk("adc master", 16'h0000, {6'h00, adc_pins, adc_main});
    rchk("status master", 7'h03, 8'h1d);
    rchk("pointer master", 7'h04, 8'h55);
    rchk("pc latch master", 7'h0a, 8'h00);
    pulse(2);
    rchk("status watchdog", 7'h03, 8'h0d);
    sel_bank(1'b1);
    i_cpu_model.wr(7'h07, 8'h03);
    i_cpu_model.wr(7'h06, 8'h00);
    pulse(0);
    chk("b_dir brown", 16'h00ff, 16'(ports.b_dir));
    chk("latches brown", 16'h0000, {3'h0, ports.a_latch, ports.b_latch});
    chk("intr brown", 16'h0000, 16'(intr_flags));
    rchk("status brown", 7'h03, 8'h18);
    rchk("pointer brown", 7'h04, 8'h00);
    sel_bank(1'b1);
    rchk("cause brown", 7'h07, 8'h02);
    $display("test resets done");
  endtask

  // ***************************************
  // main sequence and watchdog
  // ***************************************
  initial begin
    n_fail = 0;
    num_checks = 0;
    resetn = 1'b0;
    brown_out_reset = 1'b0;
    external_master_reset = 1'b0;
    watchdog_reset = 1'b0;
    ce = 1'b1;
    first_port_pins = 5'h15;
    second_port_pins = 8'ha3;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    t_reset();
    t_unmapped();
    t_indirect();
    t_bank();
    t_pc();
    t_resets();
    give_verdict();
  end

  // the tests need well under a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    give_verdict();
  end
endmodule
